// ===== common/sclkc_pkg.sv
// Package of the system clock controller: register map, fields, reset values, timing.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package sclkc_pkg;

  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned REG_AW = 6;

  localparam logic [REG_AW-1:0] ADDR_INTERNAL_CLOCK = 6'h00;
  localparam logic [REG_AW-1:0] ADDR_EXTERNAL_CLOCK = 6'h04;
  localparam logic [REG_AW-1:0] ADDR_SYS_SELECT = 6'h08;
  localparam logic [REG_AW-1:0] ADDR_SYS_DIVIDER = 6'h0c;
  localparam logic [REG_AW-1:0] ADDR_BEEPER_CLOCK = 6'h10;
  localparam logic [REG_AW-1:0] ADDR_RTC_CLOCK = 6'h14;
  localparam logic [REG_AW-1:0] ADDR_PERIPH_ENABLE = 6'h18;
  localparam logic [REG_AW-1:0] ADDR_RC_CALIBRATION = 6'h1c;
  localparam logic [REG_AW-1:0] ADDR_RC_TRIM = 6'h20;
  localparam logic [REG_AW-1:0] ADDR_RC_UNLOCK = 6'h24;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 6'h28;

  // Internal clock register fields.
  localparam int unsigned BIT_FAST_RC_ON = 0;
  localparam int unsigned BIT_SLOW_RC_ON = 1;
  localparam int unsigned BIT_FAST_WAKEUP = 2;
  // External clock register fields.
  localparam int unsigned BIT_FAST_EXT_ENABLE = 0;
  localparam int unsigned BIT_FAST_EXT_BYPASS = 1;
  localparam int unsigned BIT_SLOW_XTAL_ON = 2;
  localparam int unsigned BIT_FAST_EXT_READY = 3;

  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hac;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h35;

  localparam logic [2:0] RESET_DIV_LOG2 = 3'h3;
  localparam logic [7:0] RESET_SETTLE_COUNT = 8'h01;
  localparam logic [3:0] RESET_INTERNAL_CLOCK = 4'h3;

  typedef enum logic [1:0] {
    SCLKC_SRC_FAST_RC,
    SCLKC_SRC_FAST_EXT,
    SCLKC_SRC_SLOW_XTAL,
    SCLKC_SRC_SLOW_RC
  } sclkc_src_e;

  typedef struct packed {
    logic fast_internal_rc;
    logic fast_external_osc;
    logic slow_external_crystal;
    logic slow_internal_rc;
  } sclkc_osc_s;

endpackage : sclkc_pkg

// ===== core/sclkc_top.sv
// System clock controller: source selection, prescaler, side clocks, trim lock.
// Oscillator inputs are clock-rate toggling levels taken as synchronous to CORE_CLK.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sclkc_top #(
  parameter int unsigned PERIPH_WIDTH = 20,
  parameter int unsigned RTC_DIV_MAX_LOG2 = 6,
  parameter logic [7:0] FACTORY_TRIM = 8'h80,
  parameter logic [7:0] SETTLE_COUNT = sclkc_pkg::RESET_SETTLE_COUNT
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [sclkc_pkg::REG_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire sclkc_pkg::sclkc_osc_s OSC_INPUT_PIN_CLOCKS,
  input wire logic OSC_INPUT_PIN,
  input wire logic FAST_EXT_FAIL,
  input wire logic HALT_ENTER,
  input wire logic HALT_WAKE,
  output sclkc_pkg::sclkc_osc_s OSC_ENABLE,
  output logic OSC_OUTPUT_PIN_FREE,
  output logic [7:0] RC_TRIM_OUT,
  output logic SYSTEM_CLOCK_OUT,
  output logic [PERIPH_WIDTH-1:0] PERIPH_CLOCK,
  output logic BEEPER_CLOCK,
  output logic RTC_CLOCK,
  output logic WATCHDOG_CLOCK
);
  import sclkc_pkg::*;

  // Reset enters asynchronously but leaves through two flops.
  // All state therefore leaves reset on one common clock edge.
  logic rst_sync1, rst_sync2;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end
  wire logic rst_n = rst_sync2;

  // Registers.
  logic [3:0] internal_clock;
  logic [2:0] external_clock;
  logic [1:0] sys_select;
  logic [2:0] sys_div_log2;
  logic [1:0] beeper_source_select;
  logic [7:0] rtc_clock_register;
  logic [PERIPH_WIDTH-1:0] periph_enable;
  logic [7:0] rc_factory_calibration;
  logic [7:0] rc_trim_value;
  logic fast_ext_ready;
  logic [1:0] unlock_stage;
  logic [1:0] current_src;

  // Every access is answered one cycle after it is taken. The ack term keeps a request that
  // is still held during the ack cycle from being taken a second time.
  wire logic access = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire logic wr = access && WB_WE_I && WB_SEL_I[0];
  wire logic [7:0] wd = WB_DAT_I[7:0];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= access;
    end
  end

  // Read data is captured at the taking edge and stands until the next access.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_DAT_O <= 32'h0;
    end else if (access) begin
      if (WB_ADR_I == ADDR_INTERNAL_CLOCK) begin
        WB_DAT_O <= {28'h0, internal_clock};
      end else if (WB_ADR_I == ADDR_EXTERNAL_CLOCK) begin
        WB_DAT_O <= {28'h0, fast_ext_ready, external_clock};
      end else if (WB_ADR_I == ADDR_SYS_SELECT) begin
        WB_DAT_O <= {30'h0, sys_select};
      end else if (WB_ADR_I == ADDR_SYS_DIVIDER) begin
        WB_DAT_O <= {29'h0, sys_div_log2};
      end else if (WB_ADR_I == ADDR_BEEPER_CLOCK) begin
        WB_DAT_O <= {30'h0, beeper_source_select};
      end else if (WB_ADR_I == ADDR_RTC_CLOCK) begin
        WB_DAT_O <= {24'h0, rtc_clock_register};
      end else if (WB_ADR_I == ADDR_PERIPH_ENABLE) begin
        WB_DAT_O <= 32'(periph_enable);
      end else if (WB_ADR_I == ADDR_RC_CALIBRATION) begin
        WB_DAT_O <= {24'h0, rc_factory_calibration};
      end else if (WB_ADR_I == ADDR_RC_TRIM) begin
        WB_DAT_O <= {24'h0, rc_trim_value};
      end else if (WB_ADR_I == ADDR_STATUS) begin
        WB_DAT_O <= {30'h0, current_src};
      end else begin
        WB_DAT_O <= 32'h0;
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      internal_clock <= RESET_INTERNAL_CLOCK;
      external_clock <= 3'h0;
      sys_select <= 2'(SCLKC_SRC_FAST_RC);
      sys_div_log2 <= RESET_DIV_LOG2;
      beeper_source_select <= 2'h0;
      rtc_clock_register <= 8'h0;
      periph_enable <= '0;
    end else if (wr) begin
      if (WB_ADR_I == ADDR_INTERNAL_CLOCK) begin
        internal_clock <= wd[3:0];
      end else if (WB_ADR_I == ADDR_EXTERNAL_CLOCK) begin
        external_clock <= wd[2:0];
      end else if (WB_ADR_I == ADDR_SYS_SELECT) begin
        sys_select <= wd[1:0];
      end else if (WB_ADR_I == ADDR_SYS_DIVIDER) begin
        sys_div_log2 <= wd[2:0];
      end else if (WB_ADR_I == ADDR_BEEPER_CLOCK) begin
        beeper_source_select <= wd[1:0];
      end else if (WB_ADR_I == ADDR_RTC_CLOCK) begin
        rtc_clock_register <= wd;
      end else if (WB_ADR_I == ADDR_PERIPH_ENABLE) begin
        periph_enable <= WB_DAT_I[PERIPH_WIDTH-1:0];
      end
    end
  end

  // Factory trim is captured after reset release, never under the reset itself.
  logic cal_loaded;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cal_loaded <= 1'b0;
      rc_factory_calibration <= 8'h0;
    end else if (!cal_loaded) begin
      cal_loaded <= 1'b1;
      rc_factory_calibration <= FACTORY_TRIM;
    end
  end

  // Unlock stage 0 locked, 1 first key seen, 2 open for one trim write.
  // Reads count as foreign accesses too, so a status poll between the keys relocks.
  wire logic trim_write = wr && WB_ADR_I == ADDR_RC_TRIM && unlock_stage == 2'h2;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      unlock_stage <= 2'h0;
    end else if (access) begin
      if (wr && WB_ADR_I == ADDR_RC_UNLOCK && wd == UNLOCK_KEY_FIRST && unlock_stage == 2'h0) begin
        unlock_stage <= 2'h1;
      end else if (wr && WB_ADR_I == ADDR_RC_UNLOCK && wd == UNLOCK_KEY_SECOND
                   && unlock_stage == 2'h1) begin
        unlock_stage <= 2'h2;
      end else begin
        unlock_stage <= 2'h0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rc_trim_value <= 8'h0;
    end else if (!cal_loaded) begin
      rc_trim_value <= FACTORY_TRIM;
    end else if (trim_write) begin
      rc_trim_value <= wd;
    end
  end

  // Fast external settle: count source edges while enabled, then raise ready.
  // A failure report drops ready at once, so the selection falls back to the fast RC.
  // The count restarts from zero on every new enable, never from a stale value.
  logic fast_ext_prev;
  logic [7:0] settle_cnt;
  wire logic fast_ext_on = external_clock[BIT_FAST_EXT_ENABLE];
  wire logic fast_ext_bypass = external_clock[BIT_FAST_EXT_BYPASS];
  wire logic fast_ext_src = fast_ext_bypass ? OSC_INPUT_PIN : OSC_INPUT_PIN_CLOCKS.fast_external_osc;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fast_ext_prev <= 1'b0;
      settle_cnt <= 8'h0;
      fast_ext_ready <= 1'b0;
    end else begin
      fast_ext_prev <= fast_ext_src;
      if (!fast_ext_on || FAST_EXT_FAIL) begin
        settle_cnt <= 8'h0;
        fast_ext_ready <= 1'b0;
      end else if (fast_ext_src && !fast_ext_prev && !fast_ext_ready) begin
        if (settle_cnt + 8'h1 >= SETTLE_COUNT) begin
          fast_ext_ready <= 1'b1;
        end
        settle_cnt <= settle_cnt + 8'h1;
      end
    end
  end

  // Source selection with halt memory and fast RC backup.
  // The selection register is left untouched through a halt, so the source that ran
  // before the halt needs no saved copy to be resumed.
  logic halted;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (HALT_ENTER && !halted) begin
      halted <= 1'b1;
    end else if (HALT_WAKE && halted) begin
      halted <= 1'b0;
    end
  end

  // Fast wakeup only forces the fast RC; clearing it is left to a new source choice,
  // so a wake without the bit keeps whatever source ran before the halt.
  logic wake_fast;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wake_fast <= 1'b0;
    end else if (HALT_WAKE && halted && internal_clock[BIT_FAST_WAKEUP]) begin
      wake_fast <= 1'b1;
    end else if (wr && WB_ADR_I == ADDR_SYS_SELECT) begin
      wake_fast <= 1'b0;
    end
  end

  always_comb begin
    if (wake_fast) begin
      current_src = 2'(SCLKC_SRC_FAST_RC);
    end else if (sys_select == 2'(SCLKC_SRC_FAST_EXT) && !fast_ext_ready) begin
      current_src = 2'(SCLKC_SRC_FAST_RC);
    end else begin
      current_src = sys_select;
    end
  end

  logic src_clock;
  always_comb begin
    case (current_src)
      2'(SCLKC_SRC_FAST_EXT): src_clock = fast_ext_src;
      2'(SCLKC_SRC_SLOW_XTAL): src_clock = OSC_INPUT_PIN_CLOCKS.slow_external_crystal;
      2'(SCLKC_SRC_SLOW_RC): src_clock = OSC_INPUT_PIN_CLOCKS.slow_internal_rc;
      default: src_clock = OSC_INPUT_PIN_CLOCKS.fast_internal_rc;
    endcase
  end

  // Prescaler counts source rising edges; the ratio reloads only at period end.
  // The high phase ends halfway through the count, which keeps the duty cycle at half
  // for every ratio above one; with ratio one the source passes through registered.
  // A ratio written mid-period waits for the wrap, trading a late change for no runt pulse.
  logic src_prev;
  logic [6:0] div_cnt;
  logic [2:0] div_active;
  logic sys_clk;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= 1'b0;
      div_cnt <= 7'h0;
      div_active <= RESET_DIV_LOG2;
      sys_clk <= 1'b0;
    end else begin
      src_prev <= src_clock;
      if (halted) begin
        sys_clk <= 1'b0;
        div_cnt <= 7'h0;
      end else if (div_active == 3'h0) begin
        sys_clk <= src_clock;
        if (src_clock && !src_prev) begin
          div_active <= sys_div_log2;
        end
      end else if (src_clock && !src_prev) begin
        if (div_cnt == 7'((8'h1 << div_active) - 8'h1)) begin
          div_cnt <= 7'h0;
          sys_clk <= 1'b1;
          div_active <= sys_div_log2;
        end else begin
          div_cnt <= div_cnt + 7'h1;
          if (div_cnt == 7'((8'h1 << div_active) >> 1) - 7'h1) begin
            sys_clk <= 1'b0;
          end
        end
      end
    end
  end

  // RTC divider for fast sources; field [7:6] source, [2:0] counter bit k giving divide by 2^(k+1) for k up to RTC_DIV_MAX_LOG2.
  logic rtc_prev;
  logic [RTC_DIV_MAX_LOG2:0] rtc_cnt;
  logic rtc_src;
  always_comb begin
    case (rtc_clock_register[7:6])
      2'(SCLKC_SRC_FAST_EXT): rtc_src = fast_ext_src;
      2'(SCLKC_SRC_SLOW_XTAL): rtc_src = OSC_INPUT_PIN_CLOCKS.slow_external_crystal;
      2'(SCLKC_SRC_SLOW_RC): rtc_src = OSC_INPUT_PIN_CLOCKS.slow_internal_rc;
      default: rtc_src = OSC_INPUT_PIN_CLOCKS.fast_internal_rc;
    endcase
  end
  wire logic rtc_fast = rtc_clock_register[7:6] == 2'(SCLKC_SRC_FAST_RC)
                        || rtc_clock_register[7:6] == 2'(SCLKC_SRC_FAST_EXT);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rtc_prev <= 1'b0;
      rtc_cnt <= '0;
    end else begin
      rtc_prev <= rtc_src;
      if (rtc_src && !rtc_prev) begin
        rtc_cnt <= rtc_cnt + {{RTC_DIV_MAX_LOG2{1'b0}}, 1'b1};
      end
    end
  end

  // Registered outputs.
  // Beeper, watchdog and slow RTC clocks lag their source by one core cycle, system, peripheral and divided RTC clocks by two.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SYSTEM_CLOCK_OUT <= 1'b0;
      PERIPH_CLOCK <= '0;
      BEEPER_CLOCK <= 1'b0;
      RTC_CLOCK <= 1'b0;
      WATCHDOG_CLOCK <= 1'b0;
      OSC_ENABLE <= '0;
      OSC_OUTPUT_PIN_FREE <= 1'b0;
      RC_TRIM_OUT <= 8'h0;
    end else begin
      SYSTEM_CLOCK_OUT <= sys_clk;
      PERIPH_CLOCK <= periph_enable & {PERIPH_WIDTH{sys_clk}};
      // Select codes other than the two slow sources hold the beeper clock low.
      BEEPER_CLOCK <= (beeper_source_select == 2'h1) ? OSC_INPUT_PIN_CLOCKS.slow_external_crystal
                    : (beeper_source_select == 2'h2) ? OSC_INPUT_PIN_CLOCKS.slow_internal_rc
                    : 1'b0;
      RTC_CLOCK <= rtc_fast ? rtc_cnt[rtc_clock_register[2:0]] : rtc_src;
      WATCHDOG_CLOCK <= OSC_INPUT_PIN_CLOCKS.slow_internal_rc;
      // The fast RC stays powered while it drives the system clock, whatever its own bit,
      // so a backup switch onto a stopped fast RC starts it one core cycle after the switch.
      OSC_ENABLE.fast_internal_rc <= internal_clock[BIT_FAST_RC_ON]
                                     || current_src == 2'(SCLKC_SRC_FAST_RC);
      OSC_ENABLE.fast_external_osc <= fast_ext_on && !fast_ext_bypass;
      OSC_ENABLE.slow_external_crystal <= external_clock[BIT_SLOW_XTAL_ON];
      OSC_ENABLE.slow_internal_rc <= internal_clock[BIT_SLOW_RC_ON];
      OSC_OUTPUT_PIN_FREE <= fast_ext_on && fast_ext_bypass;
      RC_TRIM_OUT <= rc_trim_value;
    end
  end

endmodule : sclkc_top
`default_nettype wire

// ===== verification/sclkc_top_chk.sv
// Port-level assertions for the system clock controller.
// Assumes it is bound to sclkc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sclkc_top_chk #(
  parameter int unsigned PERIPH_WIDTH = 20
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire sclkc_pkg::sclkc_osc_s OSC_INPUT_PIN_CLOCKS,
  input wire sclkc_pkg::sclkc_osc_s OSC_ENABLE,
  input wire logic OSC_OUTPUT_PIN_FREE,
  input wire logic SYSTEM_CLOCK_OUT,
  input wire logic [PERIPH_WIDTH-1:0] PERIPH_CLOCK,
  input wire logic BEEPER_CLOCK,
  input wire logic WATCHDOG_CLOCK
);
  import sclkc_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acknowledged in one cycle");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  wdog_quiet_a: assert property (
    $stable(OSC_INPUT_PIN_CLOCKS.slow_internal_rc) [*4] |=> $stable(WATCHDOG_CLOCK))
    else $error("watchdog clock moved without slow rc edge");
  wdog_follow_a: assert property (
    $changed(OSC_INPUT_PIN_CLOCKS.slow_internal_rc) |-> ##[1:3] $changed(WATCHDOG_CLOCK))
    else $error("watchdog clock does not follow slow rc");
  beeper_quiet_a: assert property (
    ($stable({OSC_INPUT_PIN_CLOCKS.slow_external_crystal, OSC_INPUT_PIN_CLOCKS.slow_internal_rc})
     && !WB_ACK_O) [*4]
    |=> $stable(BEEPER_CLOCK)) else $error("beeper clock moved without slow source edge");
  pin_free_a: assert property (OSC_OUTPUT_PIN_FREE |-> !OSC_ENABLE.fast_external_osc)
    else $error("output pin freed while crystal driver is on");
  periph_gate_a: assert property (
    |PERIPH_CLOCK |-> SYSTEM_CLOCK_OUT)
    else $error("peripheral clock high outside system clock high");
  cover property ($rose(OSC_OUTPUT_PIN_FREE));
  cover property ($rose(OSC_ENABLE.fast_external_osc));
  cover property (|PERIPH_CLOCK);
endmodule : sclkc_top_chk
bind sclkc_top sclkc_top_chk #(.PERIPH_WIDTH(PERIPH_WIDTH)) i_sclkc_top_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .OSC_INPUT_PIN_CLOCKS(OSC_INPUT_PIN_CLOCKS), .OSC_ENABLE(OSC_ENABLE),
  .OSC_OUTPUT_PIN_FREE(OSC_OUTPUT_PIN_FREE), .SYSTEM_CLOCK_OUT(SYSTEM_CLOCK_OUT),
  .PERIPH_CLOCK(PERIPH_CLOCK), .BEEPER_CLOCK(BEEPER_CLOCK), .WATCHDOG_CLOCK(WATCHDOG_CLOCK));
`default_nettype wire

// ===== verification/sclkc_osc_model.sv
// Oscillator model: the four sources and the bypass pin clock as toggling levels.
// Assumes enables come from the controller and clk runs at 125 MHz.
`timescale 1ns/1ps
`default_nettype none
module sclkc_osc_model (
  input wire logic clk,
  input wire sclkc_pkg::sclkc_osc_s enable,
  output sclkc_pkg::sclkc_osc_s osc,
  output logic pin_clk
);
  import sclkc_pkg::*;
  // Slow sources are sped up, since true kilohertz periods would make the run far too long.
  localparam int HALF [5] = '{11, 9, 4, 4, 4};
  int cnt [5];
  logic [4:0] lvl;
  logic [4:0] en;
  initial lvl = '0;
  initial cnt = '{default: 0};
  // The pin clock comes from outside the chip, so it runs whatever the enables say.
  assign en = {1'b1, enable};
  assign osc = lvl[3:0];
  assign pin_clk = lvl[4];
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!en[i]) begin
        lvl[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (cnt[i] == HALF[i] - 1) begin
        lvl[i] <= ~lvl[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : sclkc_osc_model
`default_nettype wire

// ===== verification/system_clock_controller_tb.sv
// Self-checking bench of the system clock controller over classic Wishbone.
// Assumes the oscillator model feeds the sources and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module system_clock_controller_tb;
  import sclkc_pkg::*;
  typedef struct packed {logic [5:0] a; logic [31:0] w; logic [31:0] r;} sclkc_row_s;
  sclkc_row_s rows [8] = '{'{ADDR_SYS_DIVIDER, 0, 0}, '{ADDR_SYS_DIVIDER, 7, 7},
    '{ADDR_BEEPER_CLOCK, 1, 1}, '{ADDR_BEEPER_CLOCK, 2, 2}, '{ADDR_RTC_CLOCK, 'hc2, 'hc2},
    '{ADDR_PERIPH_ENABLE, 'hfffff, 'hfffff}, '{ADDR_RC_CALIBRATION, 'h12, 'h80}, '{6'h3c, 5, 0}};
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, pin_in, pin_free;
  logic ext_fail = 0, halt_enter = 0, halt_wake = 0, sys_clk, beep, rtc, wdog;
  logic [5:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [7:0] trim;
  logic [19:0] periph;
  sclkc_osc_s osc_input_pin, osc_en;
  int miscompares = 0, n_checks = 0, p, h;
  sclkc_top i_sclkc_top (.CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .OSC_INPUT_PIN_CLOCKS(osc_input_pin), .OSC_INPUT_PIN(pin_in), .FAST_EXT_FAIL(ext_fail),
    .HALT_ENTER(halt_enter), .HALT_WAKE(halt_wake), .OSC_ENABLE(osc_en),
    .OSC_OUTPUT_PIN_FREE(pin_free), .RC_TRIM_OUT(trim), .SYSTEM_CLOCK_OUT(sys_clk),
    .PERIPH_CLOCK(periph), .BEEPER_CLOCK(beep), .RTC_CLOCK(rtc), .WATCHDOG_CLOCK(wdog));
  sclkc_osc_model i_sclkc_osc_model (.clk(clk), .enable(osc_en), .osc(osc_input_pin), .pin_clk(pin_in));
  initial forever #4 clk = ~clk;
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin miscompares++; stop_test(); end
  endtask : wb
  // Measures one whole period and its high phase of the system or RTC clock in core cycles.
  task automatic period(input bit use_rtc = 1'b0);
    int n;
    n = 0; p = 0; h = 0;
    while ((use_rtc ? rtc : sys_clk) !== 1'b0 && n < 4000) begin @(posedge clk); n++; end
    while ((use_rtc ? rtc : sys_clk) !== 1'b1 && n < 4000) begin @(posedge clk); n++; end
    while ((use_rtc ? rtc : sys_clk) === 1'b1 && n < 4000) begin @(posedge clk); h++; n++; end
    while ((use_rtc ? rtc : sys_clk) === 1'b0 && n < 4000) begin @(posedge clk); p++; n++; end
    p = p + h;
    if (n >= 4000) begin miscompares++; stop_test(); end
  endtask : period
  task automatic halt_cycle;
    @(posedge clk) halt_enter <= 1'b1;
    @(posedge clk) halt_enter <= 1'b0;
    repeat (4) @(posedge clk);
    halt_wake <= 1'b1;
    @(posedge clk) halt_wake <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : halt_cycle
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, ADDR_SYS_DIVIDER, 0); `CHK("divider", 32'h3, q)
    wb(0, ADDR_INTERNAL_CLOCK, 0); `CHK("internal", 32'h3, q)
    wb(0, ADDR_STATUS, 0); `CHK("source", 32'h0, q)
    `CHK("trim", 8'h80, trim)
    period(); `CHK("reset period", 64, p)
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].w);
      wb(0, rows[i].a, 0); `CHK("row", rows[i].r, q)
    end
    wb(1, ADDR_RTC_CLOCK, 'h01);
    period(1'b1); period(1'b1); `CHK("rtc period", 32, p)
    `CHK("rtc high", 16, h)
    for (int k = 0; k < 8; k++) begin
      wb(1, ADDR_SYS_DIVIDER, k);
      period(); period(); `CHK("period", 8 << k, p)
      `CHK("high phase", 4 << k, h)
    end
    wb(1, ADDR_RC_TRIM, 'h5a);
    repeat (2) @(posedge clk); `CHK("locked", 8'h80, trim)
    wb(1, ADDR_RC_UNLOCK, 'hac); wb(1, ADDR_RC_UNLOCK, 'h35); wb(1, ADDR_RC_TRIM, 'h5a);
    repeat (3) @(posedge clk); `CHK("unlocked", 8'h5a, trim)
    wb(1, ADDR_RC_TRIM, 'h11);
    repeat (2) @(posedge clk); `CHK("relocked", 8'h5a, trim)
    wb(1, ADDR_RC_UNLOCK, 'hac); wb(0, ADDR_STATUS, 0); wb(1, ADDR_RC_UNLOCK, 'h35);
    wb(1, ADDR_RC_TRIM, 'h22);
    repeat (2) @(posedge clk); `CHK("aborted", 8'h5a, trim)
    wb(1, ADDR_EXTERNAL_CLOCK, 1);
    repeat (2) @(posedge clk); `CHK("ext on", 1'b1, osc_en.fast_external_osc)
    for (int n = 0; n < 20 && q[3] !== 1'b1; n++) wb(0, ADDR_EXTERNAL_CLOCK, 0);
    `CHK("ready", 1'b1, q[3])
    wb(1, ADDR_SYS_SELECT, 1); wb(0, ADDR_STATUS, 0); `CHK("ext src", 32'h1, q)
    ext_fail <= 1'b1;
    wb(0, ADDR_STATUS, 0); wb(0, ADDR_STATUS, 0); `CHK("backup", 32'h0, q)
    wb(0, ADDR_EXTERNAL_CLOCK, 0); `CHK("not ready", 1'b0, q[3])
    ext_fail <= 1'b0;
    wb(1, ADDR_SYS_SELECT, 0);
    wb(1, ADDR_EXTERNAL_CLOCK, 0);
    repeat (2) @(posedge clk); `CHK("ext off", 1'b0, osc_en.fast_external_osc)
    wb(1, ADDR_EXTERNAL_CLOCK, 3);
    repeat (2) @(posedge clk); `CHK("pin free", 1'b1, pin_free)
    `CHK("bypass xtal off", 1'b0, osc_en.fast_external_osc)
    wb(1, ADDR_EXTERNAL_CLOCK, 0);
    repeat (2) @(posedge clk); `CHK("pin back", 1'b0, pin_free)
    wb(1, ADDR_SYS_SELECT, 3); wb(1, ADDR_INTERNAL_CLOCK, 7); halt_cycle();
    wb(0, ADDR_STATUS, 0); `CHK("fast wake", 32'h0, q)
    wb(1, ADDR_INTERNAL_CLOCK, 3); wb(1, ADDR_SYS_SELECT, 3); halt_cycle();
    wb(0, ADDR_STATUS, 0); `CHK("same wake", 32'h3, q)
    stop_test();
  end
endmodule : system_clock_controller_tb
`default_nettype wire
